// >>> shared/mem_port_pkg.sv
/*
 * Constants, field layouts and carrier types for the synchronous memory
 * port controller. Assumes a single system clock and no register bus.
 */
// What this block does
// RL1 - sync reads wait programmable 0-3 cycle latency
// RL2 - sync writes present data after 0-3 cycles
// RL3 - extension clear: chip select off after command
// RL4 - extension set: chip select follows output enable
// RL5 - mode clear: address strobe plus deselect cycles
// RL6 - mode set: fifo read enable, no deselect
// RL7 - each space runs on its selected clock
// RL8 - sync access: pins are strobe, oe, we
// RL9 - sdram access: pins are cas, ras, we
// RL10 - peripheral strobe only for selected dma transfers
// RL11 - peripheral read data is not captured
// RL12 - peripheral write leaves data bus undriven
// RL13 - peripheral strobe delayed by read latency field
// RL14 - peripheral strobe delayed by write latency field
// RL15 - sdram reads use column latency three
// RL16 - sdram precharge, refresh, mode set, self refresh
// RL17 - separate secondary control per chip space
// RL18 - sdram commands use standard pin truth table
package mem_port_pkg;

	localparam int NUM_SPACES        = 4;
	localparam int DATA_W            = 32;
	localparam int ADDR_W            = 20;
	localparam int PRECHARGE_ALL_BIT = 10;
	localparam logic [2:0] SDRAM_CAS_LATENCY = 3'h3;

	// per space secondary control
	typedef struct packed {
		logic [1:0] sync_read_latency;
		logic [1:0] sync_write_latency;
		logic       chip_select_extend;
		logic       read_enable_mode;
		logic       sync_clock_select;
	} space_secondary_control_type;

	typedef struct packed {
		logic [1:0] peripheral_read_latency;
		logic [1:0] peripheral_write_latency;
	} peripheral_transfer_control_type;

	typedef enum logic [3:0] {
		OP_SYNC_READ   = 4'h0,
		OP_SYNC_WRITE  = 4'h1,
		OP_SD_ACTIVATE = 4'h2,
		OP_SD_READ     = 4'h3,
		OP_SD_WRITE    = 4'h4,
		OP_SD_DEACT_ALL  = 4'h5,
		OP_SD_DEACT_BANK = 4'h6,
		OP_SD_REFRESH  = 4'h7,
		OP_SD_MODE_SET = 4'h8,
		OP_SD_SELF_ENTER = 4'h9,
		OP_SD_SELF_EXIT  = 4'hA
	} op_type;

	typedef struct packed {
		op_type              op;
		logic [1:0]          space;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
		logic                peripheral_select;
	} mem_req_type;

	// shared pins: strobe pin, output enable pin, write enable pin
	typedef struct packed {
		logic strobe_n;
		logic oe_n;
		logic we_n;
	} ctl_pins_type;

	// sdram order {cas, ras, we}
	localparam ctl_pins_type PINS_IDLE     = 3'h7;
	localparam ctl_pins_type PINS_ACTIVATE = 3'h5;
	localparam ctl_pins_type PINS_READ     = 3'h3;
	localparam ctl_pins_type PINS_WRITE    = 3'h2;
	localparam ctl_pins_type PINS_PRECHARGE = 3'h4;
	localparam ctl_pins_type PINS_REFRESH  = 3'h1;
	localparam ctl_pins_type PINS_MODE_SET = 3'h0;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_CMD   = 5'h02,
		ST_WAIT  = 5'h04,
		ST_DATA  = 5'h08,
		ST_DESEL = 5'h10
	} state_type;

endpackage

// >>> verilog/edge_sync.sv
/*
 * Two flip-flop synchroniser for a vector of outside levels, with a
 * rising edge pulse per bit. Assumes inputs are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] prev_ff;

	// ----------------------------------------
	// synchroniser, first stage read only by second
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			// reset high: a clock pin already high at release gives no false edge
			meta_ff <= '1;
			sync_ff <= '1;
			prev_ff <= '1;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign level = sync_ff;
	assign rise  = sync_ff & ~prev_ff;
endmodule // edge_sync
`default_nettype wire

// >>> verilog/tick_delay.sv
/*
 * Delays a one-tick event by 0 to 3 memory clock ticks and holds the
 * active-low strobe for one memory cycle. Fire arrives only with tick.
 */
`timescale 1ns/1ps
`default_nettype none
module tick_delay (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       tick,
	input  wire logic       fire,
	input  wire logic [1:0] lat,
	output logic            strobe_n
);
	logic [3:0] pend_ff;
	logic       strobe_n_ff;
	logic [3:0] merged;

	// a pending slot per latency so back to back events do not collide
	assign merged = pend_ff | (fire ? (4'h1 << lat) : 4'h0);

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pend_ff     <= 4'h0;
			strobe_n_ff <= 1'b1;
		end else if (tick) begin
			strobe_n_ff <= ~merged[0]; // RL13
			pend_ff     <= merged >> 1; // RL14
		end
	end

	assign strobe_n = strobe_n_ff;
endmodule // tick_delay
`default_nettype wire

// >>> verilog/sync_memory_port_control.sv
/*
 * Synchronous memory port: burst SRAM, fifo and sdram access sequencer
 * with peripheral transfer strobe. Memory clocks come in as pins and
 * are sampled by sys_clk; the pins move one memory cycle per tick.
 */
`timescale 1ns/1ps
`default_nettype none
module sync_memory_port_control
	import mem_port_pkg::*;
(
	input  wire logic                            sys_clk,
	input  wire logic                            rst_b,
	input  wire logic                            mem_clock_out_a,
	input  wire logic                            mem_clock_out_b,
	input  wire space_secondary_control_type [NUM_SPACES-1:0] space_secondary_control,
	input  wire peripheral_transfer_control_type peripheral_transfer_control,
	input  wire logic                            req_valid,
	input  wire mem_req_type                     req,
	output logic                                 req_ready,
	output logic                                 op_done,
	output logic [DATA_W-1:0]                    rsp_data,
	input  wire logic [DATA_W-1:0]               data_in,
	output logic [DATA_W-1:0]                    data_out,
	output logic                                 data_oe_n,
	output logic [ADDR_W-1:0]                    mem_addr,
	output logic [NUM_SPACES-1:0]                space_chip_select_n,
	output ctl_pins_type                         ctl_pins,
	output logic                                 sdram_clock_enable,
	output logic                                 peripheral_transfer_strobe_n
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	state_type                   state_ff;
	mem_req_type                 cur_ff;
	space_secondary_control_type cur_cfg;
	space_secondary_control_type req_cfg;
	logic [2:0]        count_ff;
	logic [2:0]        issue_count;
	logic [1:0]        clk_rise;
	logic [DATA_W-1:0] data_sync;
	logic              tick;
	logic              at_issue;
	logic              step;
	logic              last_read;
	logic              write_go;
	logic              finish;
	logic              desel_end;
	logic              req_rd;
	logic              req_wr;
	logic              req_sync;
	logic              cur_rd;
	logic              cur_wr;
	logic              cur_sync;
	logic              issue_wdata;
	logic              strobe_fire;
	logic [1:0]        strobe_lat;
	logic [NUM_SPACES-1:0] cs_n_ff;
	ctl_pins_type      ctl_ff;
	logic [DATA_W-1:0] data_out_ff;
	logic              data_oe_n_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic              cke_ff;
	logic [DATA_W-1:0] rsp_data_ff;
	logic              done_ff;
	ctl_pins_type      nxt_cmd;

	// ----------------------------------------
	// input sampling
	// ----------------------------------------
	edge_sync #(.WIDTH(2)) u_clk_sync (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.async_in ({mem_clock_out_b, mem_clock_out_a}),
		.level    (),
		.rise     (clk_rise)
	);

	// data takes the same two stages, so it lines up with the clock edge
	edge_sync #(.WIDTH(DATA_W)) u_data_sync (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.async_in (data_in),
		.level    (data_sync),
		.rise     ()
	);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	// each space carries its own settings
	assign req_cfg = space_secondary_control[req.space]; // RL17
	assign cur_cfg = space_secondary_control[cur_ff.space]; // RL17

	assign req_rd   = (req.op == OP_SYNC_READ) || (req.op == OP_SD_READ);
	assign req_wr   = (req.op == OP_SYNC_WRITE) || (req.op == OP_SD_WRITE);
	assign req_sync = (req.op == OP_SYNC_READ) || (req.op == OP_SYNC_WRITE);
	assign cur_rd   = (cur_ff.op == OP_SYNC_READ) || (cur_ff.op == OP_SD_READ);
	assign cur_wr   = (cur_ff.op == OP_SYNC_WRITE) || (cur_ff.op == OP_SD_WRITE);
	assign cur_sync = (cur_ff.op == OP_SYNC_READ) || (cur_ff.op == OP_SYNC_WRITE);

	// idle follows the clock of the space being asked for
	assign tick = (state_ff == ST_IDLE) ? clk_rise[req_cfg.sync_clock_select]
		: clk_rise[cur_cfg.sync_clock_select]; // RL7

	assign at_issue  = (state_ff == ST_IDLE) && req_valid && tick;
	assign req_ready = at_issue;
	assign step      = ((state_ff == ST_CMD) || (state_ff == ST_WAIT)) && tick;
	assign last_read = step && cur_rd && (count_ff == 3'h1);
	assign write_go  = step && cur_wr && (count_ff == 3'h1);
	assign finish    = last_read || (step && !cur_rd && !cur_wr)
		|| ((state_ff == ST_DATA) && tick);
	assign desel_end = (state_ff == ST_DESEL) && tick;

	// edge that samples read data is count ticks after the command
	always_comb begin
		issue_count = 3'h0;
		if (req.op == OP_SYNC_READ)
			issue_count = {1'b0, req_cfg.sync_read_latency} + 3'h1; // RL1
		else if (req.op == OP_SD_READ)
			issue_count = SDRAM_CAS_LATENCY; // RL15
		else if (req.op == OP_SYNC_WRITE)
			issue_count = {1'b0, req_cfg.sync_write_latency}; // RL2
	end
	assign issue_wdata = at_issue && req_wr && (issue_count == 3'h0);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_ff <= ST_IDLE;
			count_ff <= 3'h0;
			cur_ff   <= '0;
		end else begin
			unique case (state_ff)
				ST_IDLE: if (at_issue) begin
					cur_ff   <= req;
					count_ff <= issue_count;
					state_ff <= issue_wdata ? ST_DATA : ST_CMD;
				end
				ST_CMD, ST_WAIT: if (step) begin
					count_ff <= count_ff - 3'h1;
					if (write_go)
						state_ff <= ST_DATA;
					else if (finish)
						state_ff <= (cur_sync && !cur_cfg.read_enable_mode)
							? ST_DESEL : ST_IDLE; // RL5 RL6
					else
						state_ff <= ST_WAIT;
				end
				ST_DATA: if (tick) begin
					state_ff <= (cur_sync && !cur_cfg.read_enable_mode)
						? ST_DESEL : ST_IDLE; // RL5 RL6
				end
				ST_DESEL: if (desel_end) begin
					state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// command pins
	// ----------------------------------------
	// sdram ops map onto {cas, ras, we}; sync ops onto strobe, oe, we
	always_comb begin
		nxt_cmd = PINS_IDLE;
		unique case (req.op)
			OP_SYNC_READ:  nxt_cmd = '{strobe_n: 1'b0, oe_n: 1'b0, we_n: 1'b1}; // RL8
			OP_SYNC_WRITE: nxt_cmd = '{strobe_n: 1'b0, oe_n: 1'b1, we_n: 1'b0}; // RL8
			OP_SD_ACTIVATE: nxt_cmd = PINS_ACTIVATE; // RL9 RL18
			OP_SD_READ:    nxt_cmd = PINS_READ; // RL18
			OP_SD_WRITE:   nxt_cmd = PINS_WRITE; // RL18
			OP_SD_DEACT_ALL, OP_SD_DEACT_BANK: nxt_cmd = PINS_PRECHARGE; // RL16
			OP_SD_REFRESH, OP_SD_SELF_ENTER: nxt_cmd = PINS_REFRESH; // RL16
			OP_SD_MODE_SET: nxt_cmd = PINS_MODE_SET; // RL16
			OP_SD_SELF_EXIT: nxt_cmd = PINS_IDLE;
			default:       nxt_cmd = PINS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cs_n_ff <= '1;
			ctl_ff  <= PINS_IDLE;
			addr_ff <= '0;
			cke_ff  <= 1'b1;
		end else if (at_issue) begin
			ctl_ff  <= nxt_cmd;
			addr_ff <= req.addr;
			if (req.op == OP_SD_DEACT_ALL)
				addr_ff[PRECHARGE_ALL_BIT] <= 1'b1; // RL16
			if (req.op == OP_SD_DEACT_BANK)
				addr_ff[PRECHARGE_ALL_BIT] <= 1'b0; // RL16
			cs_n_ff <= '1;
			// self refresh exit is a no-operation with the clock enable raised
			if (req.op != OP_SD_SELF_EXIT)
				cs_n_ff[req.space] <= 1'b0;
			if (req.op == OP_SD_SELF_ENTER)
				cke_ff <= 1'b0; // RL16
			if (req.op == OP_SD_SELF_EXIT)
				cke_ff <= 1'b1; // RL16
		end else if (finish || desel_end) begin
			// deselect cycle is all pins high; wins so a zero latency read drops oe
			ctl_ff  <= PINS_IDLE; // RL5
			cs_n_ff <= '1; // RL4
		end else if (step && (state_ff == ST_CMD)) begin
			// command lasts one memory cycle; sync read keeps oe to the data
			ctl_ff <= '{strobe_n: 1'b1, oe_n: !(cur_sync && cur_rd), we_n: 1'b1};
			if (!(cur_sync && cur_rd && cur_cfg.chip_select_extend))
				cs_n_ff <= '1; // RL3
		end
	end

	// ----------------------------------------
	// data bus and answer
	// ----------------------------------------
	// a peripheral write never drives the bus; the peripheral does
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			data_out_ff  <= '0;
			data_oe_n_ff <= 1'b1;
		end else if (issue_wdata) begin
			data_out_ff  <= req.wdata;
			data_oe_n_ff <= req.peripheral_select; // RL12
		end else if (write_go) begin
			data_out_ff  <= cur_ff.wdata;
			data_oe_n_ff <= cur_ff.peripheral_select; // RL12 RL2
		end else if ((state_ff == ST_DATA) && tick) begin
			data_oe_n_ff <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rsp_data_ff <= '0;
			done_ff     <= 1'b0;
		end else begin
			done_ff <= finish;
			if (last_read && !cur_ff.peripheral_select)
				rsp_data_ff <= data_sync; // RL1 RL11
		end
	end

	// ----------------------------------------
	// peripheral transfer strobe
	// ----------------------------------------
	// data phase starts one memory cycle before the sampling edge
	assign strobe_fire = (at_issue && req.peripheral_select && ((req_rd
		&& issue_count == 3'h1) || issue_wdata))
		|| (step && cur_ff.peripheral_select && ((cur_rd && count_ff == 3'h2)
		|| write_go)); // RL10
	assign strobe_lat = ((at_issue && req_rd) || (!at_issue && cur_rd))
		? peripheral_transfer_control.peripheral_read_latency // RL13
		: peripheral_transfer_control.peripheral_write_latency; // RL14

	tick_delay u_strobe_delay (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.tick     (tick),
		.fire     (strobe_fire),
		.lat      (strobe_lat),
		.strobe_n (peripheral_transfer_strobe_n)
	);

	assign space_chip_select_n = cs_n_ff;
	assign ctl_pins            = ctl_ff;
	assign mem_addr            = addr_ff;
	assign sdram_clock_enable  = cke_ff;
	assign data_out            = data_out_ff;
	assign data_oe_n           = data_oe_n_ff;
	assign rsp_data            = rsp_data_ff;
	assign op_done             = done_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	logic [2:0] ticks_ff;
	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			ticks_ff <= 3'h0;
		else if (at_issue)
			ticks_ff <= 3'h0;
		else if (tick && ticks_ff != 3'h7)
			ticks_ff <= ticks_ff + 3'h1;
	end

	sequence s_cmd_cycle;
		(state_ff == ST_CMD) && tick;
	endsequence
	sequence s_strobe_later;
		peripheral_transfer_strobe_n ##[1:40] !peripheral_transfer_strobe_n;
	endsequence

	a_sync_read_lat: assert property (last_read && cur_ff.op == OP_SYNC_READ // RL1
		|-> ticks_ff == {1'b0, cur_cfg.sync_read_latency})
		else $error("sync read sampled at wrong edge");
	a_sync_write_lat: assert property (write_go && cur_sync // RL2
		|-> ticks_ff + 3'h1 == {1'b0, cur_cfg.sync_write_latency})
		else $error("sync write data at wrong edge");
	a_cs_release: assert property (s_cmd_cycle and !cur_cfg.chip_select_extend // RL3
		|=> &space_chip_select_n)
		else $error("chip select held after command");
	a_cs_extend: assert property (cur_sync && !ctl_pins.oe_n // RL4
		&& state_ff != ST_IDLE
		&& cur_cfg.chip_select_extend |-> !space_chip_select_n[cur_ff.space])
		else $error("chip select dropped while oe active");
	a_deselect_cycle: assert property (finish && cur_sync // RL5
		&& !cur_cfg.read_enable_mode
		|=> state_ff == ST_DESEL && ctl_pins == PINS_IDLE)
		else $error("deselect cycle missing");
	a_no_deselect: assert property (finish && cur_cfg.read_enable_mode // RL6
		|=> state_ff == ST_IDLE)
		else $error("deselect inserted in fifo mode");
	a_sync_strobe: assert property (at_issue && req_sync // RL8
		|=> !ctl_pins.strobe_n && !space_chip_select_n[cur_ff.space])
		else $error("sync command not on strobe pin");
	a_sd_read_pins: assert property (at_issue && req.op == OP_SD_READ // RL9 RL18
		|=> ctl_pins == PINS_READ)
		else $error("sdram read encoding wrong");
	a_sd_cas_three: assert property (last_read && cur_ff.op == OP_SD_READ // RL15
		|-> ticks_ff == 3'h2)
		else $error("sdram read not at cas latency three");
	a_periph_no_capture: assert property (last_read && cur_ff.peripheral_select // RL11
		|=> $stable(rsp_data))
		else $error("peripheral read data captured");
	a_periph_no_drive: assert property (state_ff == ST_DATA // RL12
		&& cur_ff.peripheral_select |-> data_oe_n)
		else $error("bus driven on peripheral write");
	a_strobe_zero_lat: assert property (strobe_fire && strobe_lat == 2'h0 // RL13 RL14
		|=> !peripheral_transfer_strobe_n)
		else $error("zero latency strobe late");
	a_strobe_one_lat: assert property (strobe_fire && strobe_lat == 2'h1 // RL13 RL14
		&& peripheral_transfer_strobe_n |=> s_strobe_later)
		else $error("one latency strobe wrong");
	a_self_refresh: assert property (at_issue && req.op == OP_SD_SELF_ENTER // RL16
		|=> !sdram_clock_enable [*8])
		else $error("clock enable not low in self refresh");
endmodule // sync_memory_port_control
`default_nettype wire

// >>> tb/mem_device_model.sv
/*
 * Behavioural stand-in for the sram, fifo and sdram parts on the port.
 * Assumes one op at a time and that it sees the pins on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module mem_device_model
	import mem_port_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic [NUM_SPACES-1:0] space_chip_select_n,
	input  wire ctl_pins_type          ctl_pins,
	input  wire logic [ADDR_W-1:0]     mem_addr,
	input  wire logic [DATA_W-1:0]     data_out,
	input  wire logic                  data_oe_n,
	output logic      [DATA_W-1:0]     data_in
);
	logic [DATA_W-1:0] store [16];
	logic [3:0]        rd_addr;
	logic [3:0]        wr_addr;
	logic [3:0]        wr_idx;
	int                hold = 0;

	initial data_in = 32'h0;

	// a read opens a drive window covering latency three on the slow clock;
	// outside it the bus toggles so stale data can never pass for a match
	always @(posedge sys_clk) begin
		// a zero latency write drives its data at the command edge itself
		wr_idx = (&space_chip_select_n == 1'b0 && ctl_pins.strobe_n == 1'b0
			&& ctl_pins.we_n == 1'b0) ? mem_addr[3:0] : wr_addr;
		if (&space_chip_select_n == 1'b0 && ctl_pins.strobe_n == 1'b0) begin
			if (ctl_pins.we_n) begin
				rd_addr <= mem_addr[3:0];
				hold <= 120;
			end else begin
				wr_addr <= mem_addr[3:0];
			end
		end else if (hold > 0) begin
			hold <= hold - 1;
		end
		if (data_oe_n == 1'b0)
			store[wr_idx] <= data_out;
		data_in <= (hold > 0) ? store[rd_addr] : ~data_in;
	end
endmodule // mem_device_model
`default_nettype wire

// >>> tb/tb.sv
/*
 * Self-checking bench for the synchronous memory port controller.
 * Assumes the device stand-in model and free running memory clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import mem_port_pkg::*;
	typedef struct {
		ctl_pins_type pins;
		int lat, gap, csg, sp, a10;
		logic [DATA_W-1:0] data;
		bit drive, cs_on;
		logic cke;
	} exp_type;

	logic sys_clk = 0, rst_b = 0, clk_a = 0, clk_b = 0, req_valid = 0;
	space_secondary_control_type [NUM_SPACES-1:0] cfg = '0;
	peripheral_transfer_control_type ptc = '0;
	mem_req_type req = '0;
	logic req_ready, op_done, data_oe_n, cke, pst_n, pst_q;
	logic [DATA_W-1:0] rsp_data, data_in, data_out, rsp_exp = '0;
	logic [DATA_W-1:0] shadow [16];
	logic [ADDR_W-1:0] mem_addr;
	logic [NUM_SPACES-1:0] cs_n;
	logic [3:0] a;
	ctl_pins_type ctl_pins;
	exp_type q[$];
	int errors = 0, checks = 0, cyc = 0, rdy_cyc, done_cyc, st_cnt = 0;
	int st_dly, csg_cnt, pend = 0, st0, base;
	bit oe_seen;
	op_type sd_ops[9] = '{OP_SD_ACTIVATE, OP_SD_WRITE, OP_SD_READ, OP_SD_DEACT_ALL,
		OP_SD_DEACT_BANK, OP_SD_REFRESH, OP_SD_MODE_SET, OP_SD_SELF_ENTER, OP_SD_SELF_EXIT};

	// clocks: memory clocks unrelated in phase, b slower so clock choice shows
	always #5 sys_clk = ~sys_clk;
	initial #3 forever #80 clk_a = ~clk_a;
	initial #37 forever #120 clk_b = ~clk_b;

	sync_memory_port_control i_sync_memory_port_control (
		.sys_clk(sys_clk), .rst_b(rst_b), .mem_clock_out_a(clk_a),
		.mem_clock_out_b(clk_b), .space_secondary_control(cfg),
		.peripheral_transfer_control(ptc), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .op_done(op_done), .rsp_data(rsp_data),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
		.mem_addr(mem_addr), .space_chip_select_n(cs_n), .ctl_pins(ctl_pins),
		.sdram_clock_enable(cke), .peripheral_transfer_strobe_n(pst_n));

	mem_device_model i_mem_device_model (
		.sys_clk(sys_clk), .space_chip_select_n(cs_n), .ctl_pins(ctl_pins),
		.mem_addr(mem_addr), .data_out(data_out), .data_oe_n(data_oe_n),
		.data_in(data_in));

	// ----------------------------------------
	// compare and report
	// ----------------------------------------
	task automatic cmp_val(input logic [DATA_W-1:0] got, exp, input string what);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_cnt(input int got, exp, input string what);
		checks++;
		if (got != exp) begin
			errors++;
			$display("CHECK FAILED %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	function automatic int per(input int s);
		return cfg[s].sync_clock_select ? 24 : 16;
	endfunction

	// monitor: pins one cycle after the take, results at op_done
	always @(posedge sys_clk) begin
		cyc++;
		if (pend == 1) begin
			cmp_val(ctl_pins, q[0].pins, "pins");
			cmp_val(cs_n, q[0].cs_on ? 4'(~(4'h1 << q[0].sp)) : 4'hF, "select");
			cmp_val(cke, q[0].cke, "clock enable");
			if (q[0].a10 >= 0)
				cmp_val(mem_addr[PRECHARGE_ALL_BIT], q[0].a10[0], "a10");
		end
		pend = 0;
		if (req_ready === 1'b1 && q.size() > 0) begin
			if (q[0].gap >= 0)
				cmp_cnt(cyc - done_cyc, q[0].gap, "gap");
			rdy_cyc = cyc;
			pend = 1;
			oe_seen = 0;
			csg_cnt = 0;
		end
		if (q.size() > 0 && ctl_pins.oe_n === 1'b0 && cs_n[q[0].sp] === 1'b1)
			csg_cnt++;
		if (data_oe_n === 1'b0)
			oe_seen = 1;
		if (pst_q === 1'b1 && pst_n === 1'b0) begin
			st_cnt++;
			st_dly = cyc - rdy_cyc;
		end
		pst_q = pst_n;
		if (op_done === 1'b1 && q.size() > 0) begin
			done_cyc = cyc;
			cmp_cnt(cyc - rdy_cyc, q[0].lat, "latency");
			cmp_val(rsp_data, q[0].data, "read data");
			cmp_cnt(oe_seen, q[0].drive, "bus drive");
			if (q[0].csg >= 0)
				cmp_cnt(csg_cnt > 0, q[0].csg, "select extend");
			void'(q.pop_front());
		end
	end

	// cycle ceiling well above the few thousand cycles the tests need
	always @(posedge sys_clk) begin
		if (cyc > 20000) begin
			errors++;
			$display("CHECK FAILED %0t timeout", $time);
			complete_run();
		end
	end

	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	task automatic do_op(input op_type op, input int sp, input logic [3:0] ad,
		input bit psel, input int gap);
		exp_type e;
		logic [DATA_W-1:0] wd;
		int p;
		wd = $urandom;
		p = per(sp);
		e = '{pins: 3'h7, lat: p + 1, gap: gap, csg: -1, sp: sp, a10: -1,
			data: rsp_exp, drive: 0, cs_on: 1, cke: 1};
		case (op)
		OP_SYNC_READ: begin
			e.pins = 3'h1;
			e.lat = p * (cfg[sp].sync_read_latency + 1) + 1;
			e.csg = !cfg[sp].chip_select_extend && cfg[sp].sync_read_latency != 0;
		end
		OP_SYNC_WRITE: begin
			e.pins = 3'h2;
			e.lat = p * (cfg[sp].sync_write_latency + 1) + 1;
			e.drive = !psel;
		end
		OP_SD_ACTIVATE: e.pins = 3'h5;
		OP_SD_READ: begin
			e.pins = 3'h3;
			e.lat = 3 * p + 1;
		end
		OP_SD_WRITE: begin
			e.pins = 3'h2;
			e.drive = !psel;
		end
		OP_SD_DEACT_ALL: begin
			e.pins = 3'h4;
			e.a10 = 1;
		end
		OP_SD_DEACT_BANK: begin
			e.pins = 3'h4;
			e.a10 = 0;
		end
		OP_SD_REFRESH: e.pins = 3'h1;
		OP_SD_MODE_SET: e.pins = 3'h0;
		OP_SD_SELF_ENTER: begin
			e.pins = 3'h1;
			e.cke = 0;
		end
		default: e.cs_on = 0;
		endcase
		if (e.drive)
			shadow[ad] = wd;
		if ((op == OP_SYNC_READ || op == OP_SD_READ) && !psel)
			rsp_exp = shadow[ad];
		e.data = rsp_exp;
		q.push_back(e);
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req <= '{op, sp[1:0], {16'h0, ad}, wd, psel};
		do @(posedge sys_clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		do @(posedge sys_clk); while (op_done !== 1'b1);
	endtask

	initial begin
		void'($urandom(83));
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		// every space set differently so a shared setting would show up
		for (int pass = 0; pass < 2; pass++) begin
			@(posedge sys_clk);
			for (int s = 0; s < NUM_SPACES; s++)
				cfg[s] <= '{s[1:0] ^ {2{pass[0]}}, ~s[1:0] ^ {2{pass[0]}},
					s[0] ^ pass[0], s[1] ^ pass[0], s[0]};
			@(posedge sys_clk);
			for (int s = 0; s < NUM_SPACES; s++) begin
				a = 4'($urandom_range(15));
				do_op(OP_SYNC_WRITE, s, a, 0, -1);
				do_op(OP_SYNC_READ, s, a, 0,
					per(s) * (2 - cfg[s].read_enable_mode) - 1);
			end
			$display("test sync pass %0d done", pass);
		end
		foreach (sd_ops[i])
			do_op(sd_ops[i], 2, 4'h5, 0, -1);
		cmp_cnt(st_cnt, 0, "strobe without peripheral");
		$display("test sdram commands done");
		for (int w = 0; w < 2; w++) begin
			for (int k = 0; k < 4; k++) begin
				@(posedge sys_clk);
				ptc <= {k[1:0], k[1:0]};
				st0 = st_cnt;
				do_op(w ? OP_SD_WRITE : OP_SD_READ, 0, 4'h5, 1, -1);
				repeat (100) @(posedge sys_clk);
				cmp_cnt(st_cnt - st0, 1, "strobe count");
				if (k == 0)
					base = st_dly;
				cmp_cnt(st_dly - base, 16 * k, "strobe delay");
			end
		end
		do_op(OP_SD_READ, 0, 4'h5, 0, -1);
		$display("test peripheral transfers done");
		complete_run();
	end
endmodule // tb
`default_nettype wire
